// file: sideband_temp_oem_responder_tb.sv
// Purpose: drives host requests and device sources, checks answers
// Assumes: 50 MHz clock, inputs changed at the falling edge
// Notes: dropped commands end in the host timeout
`timescale 1ns/1ns
`default_nettype none
`define STOR_CHK(nm, exp, got) \
  begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module sideband_temp_oem_responder_tb;
  // enterprise number value is arbitrary
  localparam logic [31:0] ENT = 32'h0000ABCD;
  logic                  clk, srst, req_valid, req_ready, req_good;
  logic [7:0]            req_type, ans_type, die_temp;
  logic [4:0]            req_chan;
  logic [31:0]           req_w0, req_w1, ans_w0, ans_w1, oem_data, oem_ret, oem_seen;
  logic                  ans_valid, ans_timeout, ans_ck, oem_req, oem_done, oem_ret_valid;
  logic [15:0]           ans_code, ans_reason, oem_reason;
  logic [1:0]            ans_words, amb_count, xcvr_present, xcvr_has_temp, xcvr_powered;
  logic [2:0][7:0]       amb_temp;
  logic [1:0][15:0]      xcvr_temp, xcvr_alarm, xcvr_warn;
  logic                  cmd_drop, cmd_unhandled;
  int                    err_total, check_count, drops, unh;
  logic [31:0]           e;

  stor_if sb ();
  stor_device #(.OEM_ENT(ENT)) i_stor_device (.clk(clk), .srst(srst), .bus(sb.dev),
    .die_temp(die_temp), .amb_count(amb_count), .amb_temp(amb_temp),
    .xcvr_present(xcvr_present), .xcvr_has_temp(xcvr_has_temp), .xcvr_powered(xcvr_powered),
    .xcvr_temp(xcvr_temp), .xcvr_alarm(xcvr_alarm), .xcvr_warn(xcvr_warn),
    .oem_req(oem_req), .oem_data(oem_data), .oem_done(oem_done), .oem_reason(oem_reason),
    .oem_ret_valid(oem_ret_valid), .oem_ret(oem_ret), .cmd_drop(cmd_drop),
    .cmd_unhandled(cmd_unhandled));
  stor_host i_stor_host (.clk(clk), .srst(srst), .bus(sb.host), .req_valid(req_valid),
    .req_ready(req_ready), .req_type(req_type), .req_chan(req_chan), .req_good(req_good),
    .req_w0(req_w0), .req_w1(req_w1), .ans_valid(ans_valid), .ans_timeout(ans_timeout),
    .ans_type(ans_type), .ans_code(ans_code), .ans_reason(ans_reason), .ans_w0(ans_w0),
    .ans_w1(ans_w1), .ans_words(ans_words), .ans_ck(ans_ck));
  stor_properties #(.OEM_ENT(ENT)) i_stor_properties (.clk(clk), .srst(srst),
    .cmd_valid(sb.cmd_valid), .cmd_ready(sb.cmd_ready), .cmd_type(sb.cmd_type),
    .cmd_chan(sb.cmd_chan), .cmd_good(sb.cmd_good), .cmd_w0(sb.cmd_w0),
    .rsp_valid(sb.rsp_valid), .rsp_chan(sb.rsp_chan), .rsp_type(sb.rsp_type),
    .rsp_code(sb.rsp_code),
    .rsp_reason(sb.rsp_reason), .rsp_w0(sb.rsp_w0), .rsp_w1(sb.rsp_w1),
    .rsp_words(sb.rsp_words), .rsp_ck(sb.rsp_ck));

  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // vendor handler answers half a cycle after each request
  always @(negedge clk)
    oem_done = oem_req;
  always @(posedge clk)
  begin
    if (cmd_drop === 1'h1) drops++;
    if (cmd_unhandled === 1'h1) unh++;
    if (oem_req === 1'h1) oem_seen <= oem_data;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic do_cmd(input logic [7:0] t, input logic [4:0] c, input logic g,
                        input logic [31:0] w0);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'h1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 50)
    begin
      err_total++;
      results();
    end
    req_type  = t;
    req_chan  = c;
    req_good  = g;
    req_w0    = w0;
    req_valid = 1'h1;
    @(negedge clk);
    req_valid = 1'h0;
    while (ans_valid !== 1'h1 && ans_timeout !== 1'h1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000)
    begin
      err_total++;
      results();
    end
  endtask

  task automatic expect_ans(input logic to, input logic full, input logic [7:0] t,
    input logic [15:0] code, input logic [15:0] rsn, input logic [31:0] w0,
    input logic [31:0] w1, input logic [1:0] wd, input logic ck);
    `STOR_CHK("timeout", to, ans_timeout)
    if (!to)
    begin
      `STOR_CHK("type", t, ans_type)
      if (full) `STOR_CHK("code", code, ans_code)
      `STOR_CHK("reason", rsn, ans_reason)
      `STOR_CHK("word0", w0, ans_w0)
      `STOR_CHK("word1", w1, ans_w1)
      `STOR_CHK("words", wd, ans_words)
      `STOR_CHK("check flag", ck, ans_ck)
    end
  endtask

  initial
  begin
    {srst, req_valid, req_good, oem_ret_valid} = 4'h8;
    {req_type, req_chan, req_w0, req_w1, oem_reason, oem_ret} = '0;
    {err_total, check_count, drops, unh} = '0;
    die_temp = 8'h3C;
    amb_count = 2'h0;
    amb_temp = {8'h33, 8'h22, 8'h11};
    {xcvr_present, xcvr_has_temp, xcvr_powered} = 6'h3F;
    xcvr_temp = {16'h2B11, 16'h1A80};
    xcvr_alarm = {16'h5A00, 16'h5000};
    xcvr_warn = {16'h5500, 16'h4B00};
    repeat (8) @(negedge clk);
    srst = 1'h0;
    for (int k = 0; k < 2; k++)
    begin
      die_temp = 8'h3C + 8'(k * 11);
      do_cmd(stor_pkg::CMD_ASIC, stor_pkg::PKG_CHAN, 1'h1, 32'h0);
      expect_ans(1'h0, 1'h1, stor_pkg::RSP_ASIC, stor_pkg::RC_OK,
        stor_pkg::RSN_NONE, {16'h0, 8'h5F, die_temp}, 32'h0, stor_pkg::WORDS_ONE, 1'h1);
    end
    $display("test chip temperature done");
    for (int k = 0; k < 4; k++)
    begin
      amb_count = 2'(k);
      e = {24'h0, 8'(k)};
      for (int i = 0; i < k; i++)
        e[8*i+8 +: 8] = amb_temp[i];
      do_cmd(stor_pkg::CMD_AMB, 5'h02, 1'h1, 32'h0);
      expect_ans(1'h0, 1'h1, stor_pkg::RSP_AMB, stor_pkg::RC_OK,
        stor_pkg::RSN_NONE, e, 32'h0, stor_pkg::WORDS_ONE, 1'h1);
    end
    $display("test ambient done");
    for (int c = 0; c < 4; c++)
    begin
      do_cmd(stor_pkg::CMD_MOD, 5'(c), 1'h1, 32'h0);
      expect_ans(1'h0, 1'h1, stor_pkg::RSP_MOD, stor_pkg::RC_OK,
        stor_pkg::RSN_NONE, {xcvr_alarm[c/2], xcvr_warn[c/2]},
        {xcvr_temp[c/2], 16'h0}, stor_pkg::WORDS_TWO, 1'h1);
    end
    for (int f = 0; f < 3; f++)
    begin
      xcvr_present  = (f == 0) ? 2'h1 : 2'h3;
      xcvr_has_temp = (f == 1) ? 2'h1 : 2'h3;
      xcvr_powered  = (f == 2) ? 2'h1 : 2'h3;
      do_cmd(stor_pkg::CMD_MOD, 5'h03, 1'h1, 32'h0);
      expect_ans(1'h0, 1'h1, stor_pkg::RSP_MOD, stor_pkg::RC_FAIL,
        stor_pkg::RSN_INFO_NA, 32'h0, 32'h0, stor_pkg::WORDS_TWO, 1'h1);
    end
    $display("test module done");
    {oem_reason, oem_ret_valid, oem_ret, req_w1} = {16'h0012, 1'h1, 32'hCAFE0001, 32'h12345678};
    do_cmd(stor_pkg::CMD_OEM, 5'h00, 1'h1, ENT);
    expect_ans(1'h0, 1'h1, stor_pkg::RSP_OEM, stor_pkg::RC_OK, 16'h8012,
      ENT, 32'hCAFE0001, stor_pkg::WORDS_TWO, 1'h0);
    `STOR_CHK("vendor data", req_w1, oem_seen)
    {oem_reason, oem_ret_valid} = {16'h0, 1'h0};
    do_cmd(stor_pkg::CMD_OEM, 5'h02, 1'h1, ENT);
    expect_ans(1'h0, 1'h1, stor_pkg::RSP_OEM, stor_pkg::RC_OK, 16'h0,
      ENT, 32'h0, stor_pkg::WORDS_ONE, 1'h0);
    do_cmd(stor_pkg::CMD_OEM, 5'h01, 1'h1, 32'h00001234);
    expect_ans(1'h0, 1'h1, stor_pkg::RSP_OEM, stor_pkg::RC_FAIL, stor_pkg::RSN_UNK_CMD,
      32'h00001234, 32'h0, stor_pkg::WORDS_ONE, 1'h0);
    $display("test vendor done");
    do_cmd(stor_pkg::CMD_ASIC, stor_pkg::PKG_CHAN, 1'h0, 32'h0);
    expect_ans(1'h1, 1'h0, 8'h0, 16'h0, 16'h0, 32'h0, 32'h0, 2'h0, 1'h0);
    `STOR_CHK("drop count", 1, drops)
    do_cmd(stor_pkg::CMD_MOD, stor_pkg::PKG_CHAN, 1'h1, 32'h0);
    expect_ans(1'h1, 1'h0, 8'h0, 16'h0, 16'h0, 32'h0, 32'h0, 2'h0, 1'h0);
    `STOR_CHK("unhandled count", 1, unh)
    $display("test silent cases done");
    results();
  end
endmodule
`default_nettype wire

// file: stor_device.sv
// Purpose: responder end, answers temperature and vendor commands
// Assumes: checksum and identifier checks done upstream, given as cmd_good
// Notes: commands it does not own are flagged on cmd_unhandled
`timescale 1ns/1ns
`default_nettype none
module stor_device #(
  parameter logic [7:0]  ASIC_LIMIT_C  = 8'h64,
  parameter logic [7:0]  ASIC_DERATE_C = 8'h05,
  parameter bit          AMB_EN        = 1'b1,
  // enterprise number value is arbitrary
  parameter logic [31:0] OEM_ENT       = 32'h0000ABCD
) (
  input  wire logic                                  clk,
  input  wire logic                                  srst,
  stor_if.dev                                        bus,
  input  wire logic [7:0]                            die_temp,
  input  wire logic [1:0]                            amb_count,
  input  wire logic [stor_pkg::NUM_AMB-1:0][7:0]     amb_temp,
  input  wire logic [stor_pkg::NUM_XCVR-1:0]         xcvr_present,
  input  wire logic [stor_pkg::NUM_XCVR-1:0]         xcvr_has_temp,
  input  wire logic [stor_pkg::NUM_XCVR-1:0]         xcvr_powered,
  input  wire logic [stor_pkg::NUM_XCVR-1:0][15:0]   xcvr_temp,
  input  wire logic [stor_pkg::NUM_XCVR-1:0][15:0]   xcvr_alarm,
  input  wire logic [stor_pkg::NUM_XCVR-1:0][15:0]   xcvr_warn,
  output logic                                       oem_req,
  output logic [31:0]                                oem_data,
  input  wire logic                                  oem_done,
  input  wire logic [15:0]                           oem_reason,
  input  wire logic                                  oem_ret_valid,
  input  wire logic [31:0]                           oem_ret,
  output logic                                       cmd_drop,
  output logic                                       cmd_unhandled
);

  stor_pkg::stor_dev_st_t st_q;
  logic [7:0]             type_q;
  logic [4:0]             chan_q;
  logic [15:0]            code_q;
  logic [15:0]            reason_q;
  logic [31:0]            w0_q;
  logic [31:0]            w1_q;
  logic [1:0]             words_q;
  logic                   ck_q;
  logic                   oem_req_q;
  logic [31:0]            oem_data_q;
  logic                   drop_q;
  logic                   unh_q;

  // decode of the incoming command
  wire                         take     = (st_q == stor_pkg::DEV_IDLE) & bus.cmd_valid;
  wire                         is_pkg   = bus.cmd_chan == stor_pkg::PKG_CHAN;
  wire                         chan_ok  = bus.cmd_chan < stor_pkg::NUM_CHAN;
  wire [stor_pkg::XW-1:0]      xi       = stor_pkg::xcvr_of(bus.cmd_chan);
  wire                         mod_ok   = xcvr_present[xi] & xcvr_has_temp[xi]
                                          & xcvr_powered[xi];
  wire [7:0]                   asic_max = ASIC_LIMIT_C - ASIC_DERATE_C;
  wire                         ent_hit  = bus.cmd_w0 == OEM_ENT;
  wire                         vend_hi  = (oem_reason == stor_pkg::RSN_NONE)
                                          | oem_reason[15];
  wire [15:0]                  vend_rsn = vend_hi ? oem_reason
                                          : (oem_reason | stor_pkg::RSN_VENDOR_BASE);
  logic [stor_pkg::NUM_AMB-1:0][7:0] amb_byte;

  // readings beyond the sensor count read as zero
  genvar gi;
  generate
    for (gi = 0; gi < stor_pkg::NUM_AMB; gi = gi + 1)
    begin : g_amb
      assign amb_byte[gi] = (2'(gi) < amb_count) ? amb_temp[gi] : 8'h00;
    end
  endgenerate

  logic        n_hand;
  logic        n_oem;
  logic [7:0]  n_type;
  logic [15:0] n_code;
  logic [15:0] n_reason;
  logic [31:0] n_w0;
  logic [31:0] n_w1;
  logic [1:0]  n_words;
  logic        n_ck;

  // response selection by command type
  always_comb
  begin
    n_hand   = 1'b0;
    n_oem    = 1'b0;
    n_type   = 8'h00;
    n_code   = stor_pkg::RC_OK;
    n_reason = stor_pkg::RSN_NONE;
    n_w0     = 32'h0000_0000;
    n_w1     = 32'h0000_0000;
    n_words  = stor_pkg::WORDS_ONE;
    n_ck     = 1'b1;
    case (bus.cmd_type)
      stor_pkg::CMD_ASIC:
      begin
        n_hand = is_pkg | chan_ok;
        n_type = stor_pkg::RSP_ASIC;
        n_w0   = {16'h0000, asic_max, die_temp};
      end
      stor_pkg::CMD_AMB:
      begin
        n_hand = AMB_EN & is_pkg;
        n_type = stor_pkg::RSP_AMB;
        n_w0   = {amb_byte[2], amb_byte[1], amb_byte[0], 6'h00, amb_count};
      end
      stor_pkg::CMD_MOD:
      begin
        n_hand  = chan_ok;
        n_type  = stor_pkg::RSP_MOD;
        n_words = stor_pkg::WORDS_TWO;
        if (mod_ok)
        begin
          n_w0 = {xcvr_alarm[xi], xcvr_warn[xi]};
          n_w1 = {xcvr_temp[xi], 16'h0000};
        end
        else
        begin
          n_code   = stor_pkg::RC_FAIL;
          n_reason = stor_pkg::RSN_INFO_NA;
        end
      end
      stor_pkg::CMD_OEM:
      begin
        n_hand = chan_ok;
        n_type = stor_pkg::RSP_OEM;
        n_ck   = 1'b0;
        n_w0   = bus.cmd_w0;
        n_oem  = ent_hit;
        if (!ent_hit)
        begin
          n_code   = stor_pkg::RC_FAIL;
          n_reason = stor_pkg::RSN_UNK_CMD;
        end
      end
      default:
      begin
        n_hand = 1'b0;
      end
    endcase
  end

  // state sequencing
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= stor_pkg::DEV_IDLE;
    end
    else
    begin
      unique case (st_q)
        stor_pkg::DEV_IDLE:
        begin
          if (take & bus.cmd_good & n_hand)
          begin
            st_q <= n_oem ? stor_pkg::DEV_OEM_WAIT : stor_pkg::DEV_RESP;
          end
        end
        stor_pkg::DEV_OEM_WAIT:
        begin
          if (oem_done)
          begin
            st_q <= stor_pkg::DEV_RESP;
          end
        end
        stor_pkg::DEV_RESP:
        begin
          if (bus.rsp_ready)
          begin
            st_q <= stor_pkg::DEV_IDLE;
          end
        end
      endcase
    end
  end

  // response fields
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      type_q   <= 8'h00;
      chan_q   <= 5'h00;
      code_q   <= 16'h0000;
      reason_q <= 16'h0000;
      w0_q     <= 32'h0000_0000;
      w1_q     <= 32'h0000_0000;
      words_q  <= 2'h0;
      ck_q     <= 1'b0;
    end
    else if (take & bus.cmd_good & n_hand)
    begin
      type_q   <= n_type;
      chan_q   <= bus.cmd_chan;
      code_q   <= n_code;
      reason_q <= n_reason;
      w0_q     <= n_w0;
      w1_q     <= n_w1;
      words_q  <= n_words;
      ck_q     <= n_ck;
    end
    else if ((st_q == stor_pkg::DEV_OEM_WAIT) & oem_done)
    begin
      reason_q <= vend_rsn;
      if (oem_ret_valid)
      begin
        w1_q    <= oem_ret;
        words_q <= stor_pkg::WORDS_TWO;
      end
    end
  end

  // side pulses
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      oem_req_q  <= 1'b0;
      oem_data_q <= 32'h0000_0000;
      drop_q     <= 1'b0;
      unh_q      <= 1'b0;
    end
    else
    begin
      oem_req_q <= take & bus.cmd_good & n_hand & n_oem;
      drop_q    <= take & ~bus.cmd_good;
      unh_q     <= take & bus.cmd_good & ~n_hand;
      if (take & bus.cmd_good & n_hand & n_oem)
      begin
        oem_data_q <= bus.cmd_w1;
      end
    end
  end

  assign bus.cmd_ready  = st_q == stor_pkg::DEV_IDLE;
  assign bus.rsp_valid  = st_q == stor_pkg::DEV_RESP;
  assign bus.rsp_type   = type_q;
  assign bus.rsp_chan   = chan_q;
  assign bus.rsp_code   = code_q;
  assign bus.rsp_reason = reason_q;
  assign bus.rsp_w0     = w0_q;
  assign bus.rsp_w1     = w1_q;
  assign bus.rsp_words  = words_q;
  assign bus.rsp_ck     = ck_q;
  assign oem_req        = oem_req_q;
  assign oem_data       = oem_data_q;
  assign cmd_drop       = drop_q;
  assign cmd_unhandled  = unh_q;

endmodule
`default_nettype wire

// file: stor_host.sv
// Purpose: controller end, issues one command and collects its answer
// Assumes: the responder shares this clock
// Notes: gives up after a fixed wait, since bad commands get no answer
`timescale 1ns/1ns
`default_nettype none
module stor_host (
  input  wire logic        clk,
  input  wire logic        srst,
  stor_if.host             bus,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_type,
  input  wire logic [4:0]  req_chan,
  input  wire logic        req_good,
  input  wire logic [31:0] req_w0,
  input  wire logic [31:0] req_w1,
  output logic             ans_valid,
  output logic             ans_timeout,
  output logic [7:0]       ans_type,
  output logic [15:0]      ans_code,
  output logic [15:0]      ans_reason,
  output logic [31:0]      ans_w0,
  output logic [31:0]      ans_w1,
  output logic [1:0]       ans_words,
  output logic             ans_ck
);

  stor_pkg::stor_hst_st_t st_q;

  logic [7:0]  ctype_q;
  logic [4:0]  cchan_q;
  logic        cgood_q;
  logic [31:0] cw0_q;
  logic [31:0] cw1_q;
  logic [11:0] cnt_q;
  logic        av_q;
  logic        to_q;
  logic [7:0]  at_q;
  logic [15:0] ac_q;
  logic [15:0] ar_q;
  logic [31:0] aw0_q;
  logic [31:0] aw1_q;
  logic [1:0]  awd_q;
  logic        ack_q;

  wire       take    = (st_q == stor_pkg::HST_IDLE) & req_valid;
  wire       got     = (st_q == stor_pkg::HST_WAIT) & bus.rsp_valid;
  wire       expire  = (st_q == stor_pkg::HST_WAIT) & ~bus.rsp_valid
                       & (cnt_q == stor_pkg::TIMEOUT_LAST);
  wire [4:0] chan_d  = (req_type == stor_pkg::CMD_AMB) ? stor_pkg::PKG_CHAN : req_chan;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q    <= stor_pkg::HST_IDLE;
      cnt_q   <= 12'h000;
      ctype_q <= 8'h00;
      cchan_q <= 5'h00;
      cgood_q <= 1'b0;
      cw0_q   <= 32'h0000_0000;
      cw1_q   <= 32'h0000_0000;
    end
    else
    begin
      unique case (st_q)
        stor_pkg::HST_IDLE:
        begin
          cnt_q <= 12'h000;
          if (take)
          begin
            st_q    <= stor_pkg::HST_SEND;
            ctype_q <= req_type;
            cchan_q <= chan_d;
            cgood_q <= req_good;
            cw0_q   <= req_w0;
            cw1_q   <= req_w1;
          end
        end
        stor_pkg::HST_SEND:
        begin
          if (bus.cmd_ready)
          begin
            st_q <= stor_pkg::HST_WAIT;
          end
        end
        stor_pkg::HST_WAIT:
        begin
          cnt_q <= cnt_q + 12'h001;
          if (got | expire)
          begin
            st_q <= stor_pkg::HST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      av_q  <= 1'b0;
      to_q  <= 1'b0;
      at_q  <= 8'h00;
      ac_q  <= 16'h0000;
      ar_q  <= 16'h0000;
      aw0_q <= 32'h0000_0000;
      aw1_q <= 32'h0000_0000;
      awd_q <= 2'h0;
      ack_q <= 1'b0;
    end
    else
    begin
      av_q <= got;
      to_q <= expire;
      if (got)
      begin
        at_q  <= bus.rsp_type;
        ac_q  <= bus.rsp_code;
        ar_q  <= bus.rsp_reason;
        aw0_q <= bus.rsp_w0;
        aw1_q <= bus.rsp_w1;
        awd_q <= bus.rsp_words;
        ack_q <= bus.rsp_ck;
      end
    end
  end

  assign bus.cmd_valid = st_q == stor_pkg::HST_SEND;
  assign bus.cmd_type  = ctype_q;
  assign bus.cmd_chan  = cchan_q;
  assign bus.cmd_good  = cgood_q;
  assign bus.cmd_w0    = cw0_q;
  assign bus.cmd_w1    = cw1_q;
  assign bus.rsp_ready = st_q == stor_pkg::HST_WAIT;
  assign req_ready     = st_q == stor_pkg::HST_IDLE;
  assign ans_valid     = av_q;
  assign ans_timeout   = to_q;
  assign ans_type      = at_q;
  assign ans_code      = ac_q;
  assign ans_reason    = ar_q;
  assign ans_w0        = aw0_q;
  assign ans_w1        = aw1_q;
  assign ans_words     = awd_q;
  assign ans_ck        = ack_q;

endmodule
`default_nettype wire

// file: stor_if.sv
// Purpose: command and response channel between controller and responder
// Assumes: both ends on one clock
// Notes: valid/ready handshake on each direction
`timescale 1ns/1ns
`default_nettype none
interface stor_if;
  logic        cmd_valid;
  logic        cmd_ready;
  logic [7:0]  cmd_type;
  logic [4:0]  cmd_chan;
  logic        cmd_good;
  logic [31:0] cmd_w0;
  logic [31:0] cmd_w1;
  logic        rsp_valid;
  logic        rsp_ready;
  logic [7:0]  rsp_type;
  logic [4:0]  rsp_chan;
  logic [15:0] rsp_code;
  logic [15:0] rsp_reason;
  logic [31:0] rsp_w0;
  logic [31:0] rsp_w1;
  logic [1:0]  rsp_words;
  logic        rsp_ck;

  modport dev (
    input  cmd_valid, cmd_type, cmd_chan, cmd_good, cmd_w0, cmd_w1, rsp_ready,
    output cmd_ready, rsp_valid, rsp_type, rsp_chan, rsp_code, rsp_reason,
    output rsp_w0, rsp_w1, rsp_words, rsp_ck
  );
  modport host (
    output cmd_valid, cmd_type, cmd_chan, cmd_good, cmd_w0, cmd_w1, rsp_ready,
    input  cmd_ready, rsp_valid, rsp_type, rsp_chan, rsp_code, rsp_reason,
    input  rsp_w0, rsp_w1, rsp_words, rsp_ck
  );
endinterface
`default_nettype wire

// file: stor_pkg.sv
// Purpose: shared constants and types for the sideband temperature and vendor responder
// Assumes: one clock for both ends, packets already parsed into words
// Notes: reason codes without a printed value are named here
package stor_pkg;

  localparam logic [7:0]  CMD_ASIC        = 8'h48;
  localparam logic [7:0]  RSP_ASIC        = 8'hC8;
  localparam logic [7:0]  CMD_AMB         = 8'h49;
  localparam logic [7:0]  RSP_AMB         = 8'hC9;
  localparam logic [7:0]  CMD_MOD         = 8'h4A;
  localparam logic [7:0]  RSP_MOD         = 8'hCA;
  localparam logic [7:0]  CMD_OEM         = 8'h50;
  localparam logic [7:0]  RSP_OEM         = 8'hD0;

  localparam logic [4:0]  PKG_CHAN        = 5'h1F;
  localparam logic [4:0]  NUM_CHAN        = 5'h04;
  localparam int          NUM_XCVR        = 2;
  localparam int          XW              = 1;
  localparam int          NUM_AMB         = 3;

  localparam logic [15:0] RC_OK           = 16'h0000;
  localparam logic [15:0] RC_FAIL         = 16'h0001;
  localparam logic [15:0] RSN_NONE        = 16'h0000;
  localparam logic [15:0] RSN_UNK_CMD     = 16'h0001;
  localparam logic [15:0] RSN_INFO_NA     = 16'h0009;
  localparam logic [15:0] RSN_VENDOR_BASE = 16'h8000;

  localparam logic [1:0]  WORDS_ONE       = 2'h1;
  localparam logic [1:0]  WORDS_TWO       = 2'h2;

  localparam int          CLK_NS          = 20;
  localparam int          RSP_TIMEOUT_NS  = 50000;
  localparam int          TIMEOUT_CYC     = RSP_TIMEOUT_NS / CLK_NS;
  localparam logic [11:0] TIMEOUT_LAST    = 12'(TIMEOUT_CYC - 1);

  typedef enum logic [1:0] {DEV_IDLE, DEV_OEM_WAIT, DEV_RESP} stor_dev_st_t;
  typedef enum logic [1:0] {HST_IDLE, HST_SEND, HST_WAIT} stor_hst_st_t;

  // channel to transceiver, two channels share one cage
  function automatic logic [XW-1:0] xcvr_of(input logic [4:0] ch);
    xcvr_of = ch[XW:1];
  endfunction

endpackage

// file: stor_properties.sv
// Purpose: assertions on the command and response channel
// Assumes: one clock, srst synchronous active high
// Notes: enterprise number handed on from the bench
`timescale 1ns/1ns
`default_nettype none
module stor_properties #(
  // enterprise number value is arbitrary
  parameter logic [31:0] OEM_ENT = 32'h0000ABCD
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_ready,
  input  wire logic [7:0]  cmd_type,
  input  wire logic [4:0]  cmd_chan,
  input  wire logic        cmd_good,
  input  wire logic [31:0] cmd_w0,
  input  wire logic        rsp_valid,
  input  wire logic [4:0]  rsp_chan,
  input  wire logic [7:0]  rsp_type,
  input  wire logic [15:0] rsp_code,
  input  wire logic [15:0] rsp_reason,
  input  wire logic [31:0] rsp_w0,
  input  wire logic [31:0] rsp_w1,
  input  wire logic [1:0]  rsp_words,
  input  wire logic        rsp_ck
);
  logic        take;
  logic        on_chan;
  logic        oem_rsp;
  logic [31:0] ent_q;
  logic [4:0]  chan_q;

  assign take    = cmd_valid & cmd_ready;
  assign on_chan = cmd_chan < stor_pkg::NUM_CHAN;
  assign oem_rsp = rsp_valid & (rsp_type == stor_pkg::RSP_OEM);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ent_q  <= 32'h0;
      chan_q <= 5'h00;
    end
    else if (take)
    begin
      ent_q  <= cmd_w0;
      chan_q <= cmd_chan;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_good(t);
    take && cmd_good && cmd_type == t;
  endsequence
  sequence s_answer(t);
    ##1 rsp_valid && rsp_type == t;
  endsequence

  a_asic_answer: assert property (s_good(stor_pkg::CMD_ASIC) ##0
    (cmd_chan == stor_pkg::PKG_CHAN || on_chan) |-> s_answer(stor_pkg::RSP_ASIC))
    else $error("chip temperature query not answered");
  a_asic_layout: assert property (rsp_valid && rsp_type == stor_pkg::RSP_ASIC |->
    rsp_w0[31:16] == 16'h0 && rsp_ck) else $error("chip temperature reply malformed");
  a_amb_answer: assert property (s_good(stor_pkg::CMD_AMB) ##0
    cmd_chan == stor_pkg::PKG_CHAN |-> s_answer(stor_pkg::RSP_AMB))
    else $error("ambient query not answered");
  a_amb_count: assert property (rsp_valid && rsp_type == stor_pkg::RSP_AMB |->
    rsp_w0[7:0] <= 8'h03 && (rsp_w0[7:0] > 8'h02 || rsp_w0[31:24] == 8'h0)
    && (rsp_w0[7:0] > 8'h01 || rsp_w0[23:16] == 8'h0)) else $error("ambient count wrong");
  a_mod_answer: assert property (s_good(stor_pkg::CMD_MOD) ##0 on_chan
    |-> s_answer(stor_pkg::RSP_MOD)) else $error("module query not answered");
  a_mod_layout: assert property (rsp_valid && rsp_type == stor_pkg::RSP_MOD |->
    rsp_w1[15:0] == 16'h0 && rsp_words == stor_pkg::WORDS_TWO) else $error("module layout");
  a_mod_na: assert property (rsp_valid && rsp_type == stor_pkg::RSP_MOD
    && rsp_code != stor_pkg::RC_OK |-> rsp_reason == stor_pkg::RSN_INFO_NA)
    else $error("module failure reason wrong");
  a_oem_unknown: assert property (oem_rsp && ent_q != OEM_ENT |->
    rsp_reason == stor_pkg::RSN_UNK_CMD) else $error("unknown enterprise reason wrong");
  a_oem_echo: assert property (oem_rsp |-> rsp_w0 == ent_q)
    else $error("enterprise number not echoed");
  a_oem_range: assert property (oem_rsp && ent_q == OEM_ENT |->
    rsp_reason == 16'h0 || rsp_reason[15]) else $error("vendor reason out of range");
  a_oem_nock: assert property (oem_rsp |-> !rsp_ck)
    else $error("vendor reply marked with checksum");
  a_drop_quiet: assert property (take && !cmd_good |=> !rsp_valid [*8])
    else $error("dropped command answered");
  a_chan_echo: assert property (rsp_valid |-> rsp_chan == chan_q)
    else $error("reply channel differs from addressed channel");
endmodule
`default_nettype wire
